// ===== rtl/uim_pkg.sv
package uim_pkg;
	localparam logic [7:0] UIM_PERIPH_ID = 8'h01;
	localparam logic [7:0] OFS_STATE_RESET = 8'h00;
	localparam logic [7:0] OFS_ENGINE_CTRL = 8'h04;
	localparam logic [7:0] OFS_DEV_ADDR = 8'h08;
	localparam logic [7:0] OFS_FUNC_CTRL = 8'h0c;
	localparam logic [7:0] OFS_OTG_CTRL = 8'h10;
	localparam logic [7:0] OFS_OTG_STATUS = 8'h14;
	localparam logic [7:0] OFS_SERIAL_CTRL = 8'h18;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h1c;
	localparam logic [7:0] OFS_HOLD_SELECT = 8'h20;
	localparam logic [7:0] OFS_PORT_MASKS = 8'h24;
	localparam logic [7:0] OFS_FRAME_COUNT = 8'h28;
	localparam logic [7:0] OFS_LAST_PID = 8'h2c;
	localparam logic [7:0] OFS_LAST_EP = 8'h30;
	localparam logic [7:0] OFS_EP_MARK = 8'h34;
	localparam logic [7:0] OFS_OTG_MASK = 8'h38;
	localparam logic [7:0] OFS_POWER_SIG = 8'h3c;
	localparam logic [7:0] OFS_PHY_CTRL = 8'h40;
	// engine control field positions
	localparam int ENG_TOKEN_PROC = 0;
	localparam int ENG_TOKEN_CHECK = 1;
	localparam int ENG_LINE_DECODE = 2;
	localparam int ENG_TIMING = 4;
	localparam int ENG_POWER_SIG = 5;
	localparam int ENG_SOF_TOKEN = 6;
	localparam int ENG_ACK_MODE = 7;
	localparam logic [7:0] ENG_WRITE_MASK = 8'hf7;
	localparam logic [7:0] OTG_WRITE_MASK = 8'hdf;
	localparam logic [3:0] SERIAL_WRITE_MASK = 4'hf;
	localparam logic [4:0] FUNC_RESET = 5'h1f;
	localparam logic [3:0] SERIAL_RESET = 4'h2;
	localparam logic [31:0] PHY_WRITE_MASK = 32'h0004_3ff0;
	localparam logic [8:0] POWER_WRITE_MASK = 9'h1ff;
	// event flag positions
	localparam int FLG_TOKEN = 6;
	localparam int FLG_SE0 = 5;
	localparam int FLG_K = 4;
	localparam int FLG_J = 3;
	localparam int FLG_CRC16 = 2;
	localparam int FLG_RXACTIVE = 1;
	localparam int FLG_RXERROR = 0;
	// line state codes and packet identifiers
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;
	localparam logic [3:0] PID_OUT = 4'h1;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hd;
	localparam logic [3:0] PID_SOF = 4'h5;
	localparam logic [4:0] CRC5_INIT = 5'h1f;
	localparam logic [4:0] CRC5_POLY = 5'h05;
	localparam logic [4:0] CRC5_RESIDUAL = 5'h0c;
	localparam logic [15:0] CRC16_INIT = 16'hffff;
	localparam logic [15:0] CRC16_POLY = 16'h8005;
	localparam logic [15:0] CRC16_RESIDUAL = 16'h800d;

	typedef struct packed {
		logic bvalid;
		logic idgnd;
		logic hostdis;
		logic vbusvld;
		logic sessvld;
		logic sessend;
	} uim_otg_status_t;

	typedef struct packed {
		logic extvbusind;
		logic drvvbusext;
		logic chrgvbus;
		logic dischrgvbus;
		logic dmpulldown;
		logic dppulldown;
		logic idpullup;
	} uim_otg_drive_t;

	typedef enum {RX_IDLE, RX_PID, RX_BODY} uim_rx_state_t;
endpackage

// ===== rtl/uim_top.sv
`timescale 1ns/1ps
module uim_top
	import uim_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic bus_req,
	input wire logic bus_write,
	input wire logic [7:0] bus_periph,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	output logic bus_ack,
	output logic [31:0] bus_rdata,
	input wire logic [1:0] utmi_linestate,
	input wire logic utmi_rxactive,
	input wire logic utmi_rxvalid,
	input wire logic utmi_rxerror,
	input wire logic [7:0] utmi_rxdata,
	input wire logic utmi_rxrcv,
	input wire logic utmi_rxdm,
	input wire logic utmi_rxdp,
	input wire uim_otg_status_t utmi_otg_status,
	output logic [2:0] utmi_opmode,
	output logic utmi_termselect,
	output logic utmi_xcvrselect,
	output uim_otg_drive_t utmi_otg_drive,
	output logic utmi_txse0,
	output logic utmi_txdata,
	output logic utmi_txenable_n,
	output logic utmi_fslsserial,
	output logic [3:0] flag_port
);
	logic [7:0] engine_control, otg_control;
	logic [6:0] device_address_filter, line_event_flags, flag_hold_select;
	logic [4:0] transceiver_function_control, last_endpoint, crc5;
	logic [3:0] serial_line_control, last_packet_id, pid;
	logic [31:0] port_flag_masks, otg_flag_mask, transceiver_control, read_value;
	logic [10:0] frame_counter;
	logic [15:0] endpoint_mark, token_bits, crc16;
	logic [8:0] power_signal_control;
	// otg status 6, serial levels 3, linestate 2, rx status 3
	logic [13:0] sync1, sync2;
	logic [7:0] rxd1, rxd2;
	logic [1:0] ls, body_cnt;
	logic sel, wr, soft_clr, rxactive, rxvalid, rxerror, rxactive_d, pkt_start, pkt_end;
	logic pid_ok, is_token, is_data, token_good, crc16_bad;
	uim_otg_status_t otg_status_flags;
	logic [2:0] serial_rx;
	uim_rx_state_t rx_state;
	logic [6:0] flag_set, flag_level, flag_clear;

	function automatic logic [4:0] crc5_byte(input logic [4:0] c, input logic [7:0] d);
		logic [4:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[3:0], 1'b0} ^ ((d[i] ^ r[4]) ? CRC5_POLY : 5'h00);
		end
		return r;
	endfunction

	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[14:0], 1'b0} ^ ((d[i] ^ r[15]) ? CRC16_POLY : 16'h0000);
		end
		return r;
	endfunction

	assign sel = bus_req && (bus_periph == UIM_PERIPH_ID);
	assign wr = sel && bus_write;
	assign soft_clr = wr && (bus_addr == OFS_STATE_RESET);

	// pins are asynchronous to clock, two stages before use
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
			rxd1 <= '0;
			rxd2 <= '0;
		end else begin
			sync1 <= {utmi_otg_status, utmi_rxrcv, utmi_rxdm, utmi_rxdp,
				utmi_linestate, utmi_rxactive, utmi_rxvalid, utmi_rxerror};
			sync2 <= sync1;
			rxd1 <= utmi_rxdata;
			rxd2 <= rxd1;
		end
	end
	assign rxerror = sync2[0];
	assign rxvalid = sync2[1];
	assign rxactive = sync2[2];
	assign ls = sync2[4:3];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxactive_d <= 1'b0;
			otg_status_flags <= '0;
			serial_rx <= '0;
		end else if (soft_clr) begin
			rxactive_d <= 1'b0;
			otg_status_flags <= '0;
			serial_rx <= '0;
		end else begin
			rxactive_d <= rxactive;
			otg_status_flags <= sync2[13:8];
			serial_rx <= sync2[7:5];
		end
	end
	assign pkt_start = rxactive && !rxactive_d;
	assign pkt_end = !rxactive && rxactive_d;

	// packet receiver: pid, then token body or data crc
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_state <= RX_IDLE;
			pid <= '0;
			pid_ok <= 1'b0;
			body_cnt <= '0;
			token_bits <= '0;
			crc5 <= CRC5_INIT;
			crc16 <= CRC16_INIT;
		end else if (soft_clr) begin
			rx_state <= RX_IDLE;
			pid <= '0;
			pid_ok <= 1'b0;
			body_cnt <= '0;
			token_bits <= '0;
			crc5 <= CRC5_INIT;
			crc16 <= CRC16_INIT;
		end else begin
			case (rx_state)
				RX_IDLE: begin
					if (pkt_start) begin
						rx_state <= RX_PID;
					end
				end
				RX_PID: begin
					body_cnt <= '0;
					crc5 <= CRC5_INIT;
					crc16 <= CRC16_INIT;
					if (!rxactive) begin
						rx_state <= RX_IDLE;
					end else if (rxvalid) begin
						pid <= rxd2[3:0];
						pid_ok <= (rxd2[7:4] == ~rxd2[3:0]);
						rx_state <= RX_BODY;
					end
				end
				RX_BODY: begin
					if (!rxactive) begin
						rx_state <= RX_IDLE;
					end else if (rxvalid) begin
						crc5 <= crc5_byte(crc5, rxd2);
						crc16 <= crc16_byte(crc16, rxd2);
						if (body_cnt == 2'd0) begin
							token_bits[7:0] <= rxd2;
						end else if (body_cnt == 2'd1) begin
							token_bits[15:8] <= rxd2;
						end
						if (body_cnt != 2'd3) begin
							body_cnt <= body_cnt + 2'd1;
						end
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	assign is_token = (pid == PID_OUT) || (pid == PID_IN) || (pid == PID_SETUP) ||
		(engine_control[ENG_SOF_TOKEN] && (pid == PID_SOF));
	assign is_data = (pid[1:0] == 2'h3);
	// address filter; a start-of-frame token carries no address
	assign token_good = pkt_end && (rx_state == RX_BODY) && is_token &&
		engine_control[ENG_TOKEN_PROC] && (body_cnt == 2'd2) &&
		(!engine_control[ENG_TOKEN_CHECK] || (pid_ok && (crc5 == CRC5_RESIDUAL))) &&
		((pid == PID_SOF) || (token_bits[6:0] == device_address_filter));
	assign crc16_bad = pkt_end && (rx_state == RX_BODY) && is_data &&
		(crc16 != CRC16_RESIDUAL);

	always_comb begin
		flag_set = '0;
		flag_set[FLG_TOKEN] = token_good;
		flag_set[FLG_SE0] = engine_control[ENG_LINE_DECODE] && (ls == LS_SE0);
		flag_set[FLG_K] = engine_control[ENG_LINE_DECODE] && (ls == LS_K);
		flag_set[FLG_J] = engine_control[ENG_LINE_DECODE] && (ls == LS_J);
		flag_set[FLG_CRC16] = crc16_bad;
		flag_set[FLG_RXACTIVE] = rxactive;
		flag_set[FLG_RXERROR] = rxerror;
		flag_level = '0;
		flag_level[FLG_RXACTIVE] = 1'b1;
		flag_level[FLG_RXERROR] = 1'b1;
		flag_clear = (wr && (bus_addr == OFS_EVENT_FLAGS)) ? bus_wdata[6:0] : 7'h00;
	end

	// set wins over a write-one clear in the same cycle; soft clear wins over set
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			line_event_flags <= '0;
		end else if (soft_clr) begin
			line_event_flags <= '0;
		end else begin
			for (int i = 0; i < 7; i++) begin
				if (flag_set[i]) begin
					line_event_flags[i] <= 1'b1;
				end else if (flag_clear[i]) begin
					line_event_flags[i] <= 1'b0;
				end else if (flag_hold_select[i]) begin
					line_event_flags[i] <= line_event_flags[i];
				// normal flags follow source or clear
				end else if (flag_level[i] || pkt_start) begin
					line_event_flags[i] <= 1'b0;
				end
			end
		end
	end

	// token side effects: last pid, endpoint, frame number
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_packet_id <= '0;
			last_endpoint <= '0;
			frame_counter <= '0;
		end else if (soft_clr) begin
			last_packet_id <= '0;
			last_endpoint <= '0;
			frame_counter <= '0;
		end else if (wr && (bus_addr == OFS_FRAME_COUNT)) begin
			frame_counter <= bus_wdata[10:0];
		end else if (token_good) begin
			last_packet_id <= pid;
			if (pid == PID_SOF) begin
				frame_counter <= token_bits[10:0];
			end else begin
				last_endpoint <= {1'b1, token_bits[10:7]};
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			engine_control <= '0;
			device_address_filter <= '0;
			transceiver_function_control <= FUNC_RESET;
			otg_control <= '0;
			serial_line_control <= SERIAL_RESET;
			flag_hold_select <= '0;
			port_flag_masks <= '0;
			endpoint_mark <= '0;
			otg_flag_mask <= '0;
			power_signal_control <= '0;
			transceiver_control <= '0;
		end else if (soft_clr) begin
			engine_control <= '0;
			device_address_filter <= '0;
			transceiver_function_control <= FUNC_RESET;
			otg_control <= '0;
			serial_line_control <= SERIAL_RESET;
			flag_hold_select <= '0;
			port_flag_masks <= '0;
			endpoint_mark <= '0;
			otg_flag_mask <= '0;
			power_signal_control <= '0;
			transceiver_control <= '0;
		end else if (wr) begin
			case (bus_addr)
				OFS_ENGINE_CTRL: engine_control <= bus_wdata[7:0] & ENG_WRITE_MASK;
				OFS_DEV_ADDR: device_address_filter <= bus_wdata[6:0];
				OFS_FUNC_CTRL: transceiver_function_control <= bus_wdata[4:0];
				OFS_OTG_CTRL: otg_control <= bus_wdata[7:0] & OTG_WRITE_MASK;
				OFS_SERIAL_CTRL: serial_line_control <= bus_wdata[3:0] & SERIAL_WRITE_MASK;
				OFS_HOLD_SELECT: flag_hold_select <= bus_wdata[6:0];
				OFS_PORT_MASKS: port_flag_masks <= bus_wdata;
				OFS_EP_MARK: endpoint_mark <= bus_wdata[15:0];
				OFS_OTG_MASK: otg_flag_mask <= bus_wdata;
				OFS_POWER_SIG: power_signal_control <= bus_wdata[8:0] & POWER_WRITE_MASK;
				OFS_PHY_CTRL: transceiver_control <= bus_wdata & PHY_WRITE_MASK;
				default: engine_control <= engine_control;
			endcase
		end
	end

	always_comb begin
		read_value = 32'h0000_0000;
		case (bus_addr)
			OFS_ENGINE_CTRL: read_value = {24'h0, engine_control};
			OFS_DEV_ADDR: read_value = {25'h0, device_address_filter};
			OFS_FUNC_CTRL: read_value = {27'h0, transceiver_function_control};
			OFS_OTG_CTRL: read_value = {24'h0, otg_control};
			OFS_OTG_STATUS: read_value = {26'h0, otg_status_flags};
			OFS_SERIAL_CTRL: read_value = {25'h0, serial_rx, serial_line_control};
			OFS_EVENT_FLAGS: read_value = {25'h0, line_event_flags};
			OFS_HOLD_SELECT: read_value = {25'h0, flag_hold_select};
			OFS_PORT_MASKS: read_value = port_flag_masks;
			OFS_FRAME_COUNT: read_value = {21'h0, frame_counter};
			OFS_LAST_PID: read_value = {28'h0, last_packet_id};
			OFS_LAST_EP: read_value = {27'h0, last_endpoint};
			OFS_EP_MARK: read_value = {16'h0, endpoint_mark};
			OFS_OTG_MASK: read_value = otg_flag_mask;
			OFS_POWER_SIG: read_value = {23'h0, power_signal_control};
			OFS_PHY_CTRL: read_value = transceiver_control;
			default: read_value = 32'h0000_0000;
		endcase
	end

	// one-cycle answer; write-only and unmapped words read zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
			bus_rdata <= '0;
		end else begin
			bus_ack <= sel;
			bus_rdata <= (sel && !bus_write) ? read_value : 32'h0000_0000;
		end
	end

	// outputs straight from flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			utmi_opmode <= FUNC_RESET[4:2];
			utmi_termselect <= 1'b1;
			utmi_xcvrselect <= 1'b1;
			utmi_otg_drive <= '0;
			utmi_txse0 <= 1'b0;
			utmi_txdata <= 1'b0;
			utmi_txenable_n <= 1'b1;
			utmi_fslsserial <= 1'b0;
			flag_port <= '0;
		end else begin
			utmi_opmode <= transceiver_function_control[4:2];
			utmi_termselect <= transceiver_function_control[1];
			utmi_xcvrselect <= transceiver_function_control[0];
			utmi_otg_drive <= {otg_control[7:6], otg_control[4:0]};
			utmi_txse0 <= serial_line_control[3];
			utmi_txdata <= serial_line_control[2];
			utmi_txenable_n <= serial_line_control[1];
			utmi_fslsserial <= serial_line_control[0];
			for (int p = 0; p < 4; p++) begin
				flag_port[p] <= |(line_event_flags & port_flag_masks[p*8 +: 7]);
			end
		end
	end

	chk_soft_clear_func: assert property (@(posedge clock) disable iff (!rst_n)
		soft_clr |=> (transceiver_function_control == FUNC_RESET) && (engine_control == 8'h00)
		##1 (utmi_opmode == 3'h7) && utmi_txenable_n) else $error("soft clear failed");
	chk_bus_answer: assert property (@(posedge clock) disable iff (!rst_n)
		sel && !bus_write && (bus_addr == OFS_DEV_ADDR) |=>
		bus_ack && (bus_rdata == {25'h0, $past(device_address_filter)}))
		else $error("read answer wrong");
	// wrong address never flags a token other than a start-of-frame
	chk_addr_filter: assert property (@(posedge clock) disable iff (!rst_n)
		token_good && (pid != PID_SOF) |-> token_bits[6:0] == device_address_filter)
		else $error("token with foreign address accepted");
	chk_opmode_drive: assert property (@(posedge clock) disable iff (!rst_n || soft_clr)
		wr && (bus_addr == OFS_FUNC_CTRL) |=> ##1 utmi_opmode == $past(bus_wdata[4:2], 2))
		else $error("opmode not driven");
	chk_token_flag: assert property (@(posedge clock) disable iff (!rst_n || soft_clr)
		token_good |=> line_event_flags[FLG_TOKEN]) else $error("token flag missed");
	chk_se0_flag: assert property (@(posedge clock) disable iff (!rst_n || soft_clr)
		engine_control[ENG_LINE_DECODE] && (ls == LS_SE0) |=> line_event_flags[FLG_SE0])
		else $error("se0 flag missed");
	chk_rxactive_follow: assert property (@(posedge clock) disable iff (!rst_n || soft_clr)
		!flag_hold_select[FLG_RXACTIVE] && !flag_clear[FLG_RXACTIVE] |=>
		line_event_flags[FLG_RXACTIVE] == $past(rxactive)) else $error("rxactive flag stale");
	// normal flag cleared at packet start
	chk_auto_clear: assert property (@(posedge clock) disable iff (!rst_n || soft_clr)
		pkt_start && !flag_hold_select[FLG_CRC16] && !flag_set[FLG_CRC16] |=>
		!line_event_flags[FLG_CRC16]) else $error("flag not cleared at packet");
	chk_hold_flag: assert property (@(posedge clock) disable iff (!rst_n || soft_clr)
		flag_hold_select[FLG_J] && line_event_flags[FLG_J] && !flag_clear[FLG_J] |=>
		line_event_flags[FLG_J]) else $error("held flag lost");
	// reserved bit of otg control reads zero
	chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
		otg_control[5] == 1'b0 && engine_control[3] == 1'b0) else $error("reserved bit set");
	cov_token: cover property (@(posedge clock) disable iff (!rst_n) token_good);
	cov_crc_bad: cover property (@(posedge clock) disable iff (!rst_n) crc16_bad);
	cov_soft: cover property (@(posedge clock) disable iff (!rst_n) soft_clr);
	cov_hold: cover property (@(posedge clock) disable iff (!rst_n)
		pkt_start && flag_hold_select[FLG_J] && line_event_flags[FLG_J]);
endmodule

// ===== test/uim_phy_model.sv
`timescale 1ns/1ps
module uim_phy_model
	import uim_pkg::*;
(
	input wire logic clock,
	output logic [1:0] linestate,
	output logic rxactive,
	output logic rxvalid,
	output logic rxerror,
	output logic [7:0] rxdata,
	output logic rxrcv,
	output logic rxdm,
	output logic rxdp,
	output uim_otg_status_t otg_status
);
	initial begin
		linestate = LS_J;
		rxactive = 1'b0;
		rxvalid = 1'b0;
		rxerror = 1'b0;
		rxdata = 8'h5a;
		rxrcv = 1'b0;
		rxdm = 1'b0;
		rxdp = 1'b0;
		otg_status = '0;
	end

	// one byte per valid strobe, gap cycle between bytes
	task automatic send(input logic [7:0] b [0:3], input int n);
		rxactive = 1'b1;
		@(posedge clock);
		#1;
		for (int i = 0; i < n; i++) begin
			rxvalid = 1'b1;
			rxdata = b[i];
			@(posedge clock);
			#1;
			rxvalid = 1'b0;
			// released bus shows the inverse, never a stale byte
			rxdata = ~b[i];
			@(posedge clock);
			#1;
		end
		rxactive = 1'b0;
		repeat (6) @(posedge clock);
		#1;
	endtask
endmodule

// ===== test/tb_usb_phy_interface_manager_regs.sv
`timescale 1ns/1ps
module tb_usb_phy_interface_manager_regs
	import uim_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic bus_req = 1'b0;
	logic bus_write = 1'b0;
	logic [7:0] bus_periph = 8'h01;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic bus_ack;
	logic [31:0] bus_rdata;
	logic [1:0] ls;
	logic rxa, rxv, rxe, rcv, dm_lvl, rdp;
	logic [7:0] rxd;
	uim_otg_status_t ost;
	uim_otg_drive_t odrv;
	logic [2:0] opmode;
	logic term, xcvr, txse0, txdata, txen_n, fsls;
	logic [3:0] fport;
	int miscompares = 0;
	int n_checks = 0;

	always #10 clock = ~clock;

	uim_phy_model phy (.clock(clock), .linestate(ls), .rxactive(rxa), .rxvalid(rxv),
		.rxerror(rxe), .rxdata(rxd), .rxrcv(rcv), .rxdm(dm_lvl), .rxdp(rdp), .otg_status(ost));

	uim_top dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_write(bus_write),
		.bus_periph(bus_periph), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_ack(bus_ack), .bus_rdata(bus_rdata), .utmi_linestate(ls), .utmi_rxactive(rxa),
		.utmi_rxvalid(rxv), .utmi_rxerror(rxe), .utmi_rxdata(rxd), .utmi_rxrcv(rcv),
		.utmi_rxdm(dm_lvl), .utmi_rxdp(rdp), .utmi_otg_status(ost), .utmi_opmode(opmode),
		.utmi_termselect(term), .utmi_xcvrselect(xcvr), .utmi_otg_drive(odrv),
		.utmi_txse0(txse0), .utmi_txdata(txdata), .utmi_txenable_n(txen_n),
		.utmi_fslsserial(fsls), .flag_port(fport));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// one-cycle request pulse, ack sampled the cycle after it is taken
	task automatic xfer(input logic wr, input logic [7:0] per, input logic [7:0] adr,
		input logic [31:0] wd, output logic [31:0] rdv, output logic acked);
		bus_req = 1'b1;
		bus_write = wr;
		bus_periph = per;
		bus_addr = adr;
		bus_wdata = wd;
		idle(1);
		bus_req = 1'b0;
		acked = bus_ack;
		rdv = bus_rdata;
		idle(1);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
		logic [31:0] rdv;
		logic ak;
		xfer(1'b1, UIM_PERIPH_ID, adr, wd, rdv, ak);
		check(ak, 1'b1);
	endtask

	task automatic rdm(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
		logic [31:0] rdv;
		logic ak;
		xfer(1'b0, UIM_PERIPH_ID, adr, 32'h0, rdv, ak);
		check(ak, 1'b1);
		check(rdv & msk, exp);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		rdm(adr, exp, 32'hffff_ffff);
	endtask

	function automatic logic [4:0] crc5_field(input logic [10:0] d);
		logic [4:0] c;
		logic fb;
		c = CRC5_INIT;
		for (int i = 0; i < 11; i++) begin
			fb = d[i] ^ c[4];
			c = {c[3:0], 1'b0};
			if (fb)
				c = c ^ CRC5_POLY;
		end
		return ~{c[0], c[1], c[2], c[3], c[4]};
	endfunction

	task automatic token(input logic [3:0] pid, input logic [6:0] adr, input logic [3:0] ep,
		input logic flip);
		logic [15:0] body;
		logic [7:0] b [0:3];
		body = {crc5_field({ep, adr}) ^ {4'h0, flip}, ep, adr};
		b[0] = {~pid, pid};
		b[1] = body[7:0];
		b[2] = body[15:8];
		b[3] = 8'h00;
		phy.send(b, 3);
	endtask

	task automatic t_reset();
		logic [31:0] rdv;
		logic ak;
		rd(OFS_ENGINE_CTRL, 32'h0);
		rd(OFS_DEV_ADDR, 32'h0);
		rd(OFS_FUNC_CTRL, 32'h1f);
		rd(OFS_OTG_CTRL, 32'h0);
		rd(OFS_OTG_STATUS, 32'h0);
		rd(OFS_SERIAL_CTRL, 32'h2);
		rd(OFS_EVENT_FLAGS, 32'h0);
		rd(OFS_HOLD_SELECT, 32'h0);
		rd(OFS_STATE_RESET, 32'h0);
		rd(8'h44, 32'h0);
		check({opmode, term, xcvr}, 5'h1f);
		check(odrv, 7'h00);
		check({txse0, txdata, txen_n, fsls}, 4'h2);
		xfer(1'b0, 8'h02, OFS_FUNC_CTRL, 32'h0, rdv, ak);
		check(ak, 1'b0);
		$display("test reset_values done");
	endtask

	task automatic t_access();
		wr(OFS_ENGINE_CTRL, 32'hffff_ffff);
		rd(OFS_ENGINE_CTRL, 32'hf7);
		wr(OFS_DEV_ADDR, 32'hffff_ffff);
		rd(OFS_DEV_ADDR, 32'h7f);
		wr(OFS_OTG_CTRL, 32'hffff_ffff);
		rd(OFS_OTG_CTRL, 32'hdf);
		check(odrv, 7'h7f);
		wr(OFS_FUNC_CTRL, 32'h2);
		rd(OFS_FUNC_CTRL, 32'h2);
		check({opmode, term, xcvr}, 5'h02);
		wr(OFS_SERIAL_CTRL, 32'hffff_ffff);
		rd(OFS_SERIAL_CTRL, 32'h0f);
		check({txse0, txdata, txen_n, fsls}, 4'hf);
		wr(OFS_OTG_STATUS, 32'hffff_ffff);
		rd(OFS_OTG_STATUS, 32'h0);
		wr(OFS_STATE_RESET, 32'h1234_5678);
		rd(OFS_ENGINE_CTRL, 32'h0);
		rd(OFS_FUNC_CTRL, 32'h1f);
		check({opmode, term, xcvr, odrv}, 12'hf80);
		check({txse0, txdata, txen_n, fsls}, 4'h2);
		$display("test access_and_soft_reset done");
	endtask

	task automatic t_status();
		phy.otg_status = 6'h2a;
		phy.rxrcv = 1'b1;
		phy.rxdp = 1'b1;
		idle(4);
		rd(OFS_OTG_STATUS, 32'h2a);
		rd(OFS_SERIAL_CTRL, 32'h52);
		$display("test status_mirror done");
	endtask

	task automatic t_tokens();
		// address left at zero until enumerated, then the assigned one
		wr(OFS_ENGINE_CTRL, 32'h03);
		wr(OFS_DEV_ADDR, 32'h05);
		token(PID_OUT, 7'h05, 4'h3, 1'b0);
		rd(OFS_EVENT_FLAGS, 32'h40);
		rd(OFS_LAST_PID, {28'h0, PID_OUT});
		rd(OFS_LAST_EP, 32'h13);
		token(PID_IN, 7'h06, 4'h2, 1'b0);
		rd(OFS_EVENT_FLAGS, 32'h0);
		token(PID_SETUP, 7'h05, 4'h1, 1'b1);
		rd(OFS_EVENT_FLAGS, 32'h0);
		// start-of-frame accepted as token, frame number loaded
		wr(OFS_ENGINE_CTRL, 32'h43);
		token(PID_SOF, 7'h2a, 4'h5, 1'b0);
		rd(OFS_EVENT_FLAGS, 32'h40);
		rd(OFS_FRAME_COUNT, 32'h2aa);
		rd(OFS_LAST_PID, {28'h0, PID_SOF});
		wr(OFS_FRAME_COUNT, 32'hffff_ffff);
		rd(OFS_FRAME_COUNT, 32'h7ff);
		$display("test tokens done");
	endtask

	task automatic t_crc16();
		logic [7:0] b [0:3] = '{8'hc3, 8'h11, 8'h22, 8'h33};
		phy.send(b, 4);
		rd(OFS_EVENT_FLAGS, 32'h04);
		$display("test crc16_fail done");
	endtask

	task automatic t_line();
		logic [1:0] codes [0:2] = '{LS_SE0, LS_K, LS_J};
		int pos [0:2] = '{FLG_SE0, FLG_K, FLG_J};
		wr(OFS_ENGINE_CTRL, 32'h04);
		for (int i = 0; i < 3; i++) begin
			phy.linestate = codes[i];
			idle(5);
			rdm(OFS_EVENT_FLAGS, 32'h1 << pos[i], 32'h1 << pos[i]);
		end
		$display("test line_flags done");
	endtask

	task automatic t_hold();
		wr(OFS_ENGINE_CTRL, 32'h0);
		wr(OFS_PORT_MASKS, 32'h0000_0002);
		phy.rxactive = 1'b1;
		phy.rxerror = 1'b1;
		idle(5);
		rdm(OFS_EVENT_FLAGS, 32'h3, 32'h3);
		check(fport, 4'h1);
		phy.rxactive = 1'b0;
		phy.rxerror = 1'b0;
		idle(5);
		rdm(OFS_EVENT_FLAGS, 32'h0, 32'h3);
		wr(OFS_HOLD_SELECT, 32'hffff_ff8b);
		rd(OFS_HOLD_SELECT, 32'h0b);
		// j flag raised briefly, then must survive the next packet start
		wr(OFS_ENGINE_CTRL, 32'h04);
		wr(OFS_ENGINE_CTRL, 32'h0);
		phy.rxactive = 1'b1;
		phy.rxerror = 1'b1;
		idle(5);
		phy.rxactive = 1'b0;
		phy.rxerror = 1'b0;
		idle(5);
		rdm(OFS_EVENT_FLAGS, 32'hb, 32'hb);
		// held flags cleared by writing one, a few bits at a time
		wr(OFS_EVENT_FLAGS, 32'h0a);
		rdm(OFS_EVENT_FLAGS, 32'h1, 32'hb);
		wr(OFS_EVENT_FLAGS, 32'h01);
		rdm(OFS_EVENT_FLAGS, 32'h0, 32'hb);
		$display("test hold_select done");
	endtask

	initial begin
		repeat (12) @(posedge clock);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_access();
		t_status();
		t_tokens();
		t_crc16();
		t_line();
		t_hold();
		complete_run();
	end
endmodule
